//--- logic/sra_defs.vh
// Constants for the receive alignment control block.
// Assumes an APB bus with register indices four bytes apart.
`ifndef SRA_DEFS_VH
`define SRA_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define SRA_IDX_CHAN_ALIGN_CTRL_A  18'h30810
`define SRA_IDX_GROUP_MODE_A       18'h30811
`define SRA_IDX_RESYNC_LINK_CTRL_A 18'h30820
`define SRA_IDX_ALIGN_BYPASS_A     18'h30821
`define SRA_IDX_CHAN_ALIGN_CTRL_B  18'h30910
`define SRA_IDX_GROUP_MODE_B       18'h30911
`define SRA_IDX_RESYNC_LINK_CTRL_B 18'h30920
`define SRA_IDX_ALIGN_BYPASS_B     18'h30921
`define SRA_IDX_LINK_SM_SEL        18'h30830
`define SRA_IDX_ALIGN_STATUS       18'h30840

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRA_BIT_REALIGN_C  2
`define SRA_BIT_MEMBER_C   6
`define SRA_BIT_SRESYNC_C  2
`define SRA_BIT_TRESYNC    5
`define SRA_BIT_XAUI       7
`define SRA_BIT_BYPASS     0

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define SRA_MASK_CHAN_CTRL 8'hcc
`define SRA_MASK_RLC       8'hac
`define SRA_MASK_BYPASS    8'h01
`define SRA_RST_REG8       8'h00
`define SRA_RST_SEL4       4'h0

// ----------------------------------------
// Group mode encodings
// ----------------------------------------
`define SRA_MODE_NONE 8'h00
`define SRA_MODE_TWIN 8'h0a
`define SRA_MODE_QUAD 8'h0f

`endif

//--- logic/sra_align_ctrl.v
// Receive alignment control: APB registers, word realign, group
// alignment buffers for four channels (AC, AD, BC, BD).
// Assumes receive channels and fabric run on pclk; no pin inputs.
// Notes on behaviour
// - Realign rising edge: realign at next comma
// - Membership 0 excludes channel from groups
// - Membership 1 joins twin or quad group
// - Mode 00 none, 0a twin, 0f quad
// - Single resync edge resets channel buffer pointers
// - Twin resync edge resyncs block's group
// - XAUI select drives both channels' XAUI machine
// - XAUI select overrides per-channel machine select
// - XAUI select clears at reset
// - Bypass routes data around alignment gating
// - Bypass clears at reset
// - Channel C membership clears at reset
// - Twin resync bit clears at reset
// - Group mode resets to none
// - Channel alignment done flag, cleared at reset
// - Word alignment done flag, cleared at reset
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "sra_defs.vh"

// ----------------------------------------
// Elastic buffer
// ----------------------------------------
module sra_fifo #(
	parameter W  = 9,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         ce,
	input  wire         clr,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data,
	output wire         afull
);
	reg [W-1:0] mem_q [0:D-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   cnt_q;
	wire         wr;
	wire         rd;

	assign in_ready  = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rp_q];
	assign afull     = (cnt_q >= D[AW:0] - 1'b1);
	assign wr        = in_valid & in_ready;
	assign rd        = out_valid & out_ready;

	always @(posedge clk) begin
		if (ce && wr)
			mem_q[wp_q] <= in_data;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (clr) begin
				wp_q  <= {AW{1'b0}};
				rp_q  <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end else begin
				if (wr)
					wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
				if (rd)
					rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
				if (wr && !rd)
					cnt_q <= cnt_q + 1'b1;
				else if (rd && !wr)
					cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // sra_fifo

// ----------------------------------------
// Alignment control top
// ----------------------------------------
module sra_align_ctrl #(
	parameter DW    = 9,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              ce,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [19:0]       paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	input  wire [3:0]        rx_valid,
	input  wire [4*DW-1:0]   rx_data,
	input  wire [3:0]        rx_comma,
	output reg  [3:0]        rx_ready,
	output reg  [3:0]        out_valid,
	output reg  [4*DW-1:0]   out_data,
	input  wire [3:0]        out_ready,
	output reg  [3:0]        word_realign,
	output reg  [3:0]        xaui_link_sm_select,
	output reg  [3:0]        word_align_done,
	output reg  [3:0]        chan_align_done
);
	// Per-block registers, index 0 = block A
	reg [7:0]  chan_ctrl_q [0:1];
	reg [7:0]  mode_q [0:1];
	reg [7:0]  rlc_q [0:1];
	reg [7:0]  byp_q [0:1];
	reg [3:0]  lsel_q;

	// Edge history and applied settings
	reg [3:0]  realign_prev_q;
	reg [3:0]  sresync_prev_q;
	reg [1:0]  tresync_prev_q;
	reg [3:0]  mem_act_q;
	reg [1:0]  twin_act_q;
	reg [1:0]  quad_act_q;
	reg [1:0]  byp_act_q;
	reg [3:0]  hunt_q;
	reg [3:0]  started_q;

	reg [3:0]  realign_p;
	reg [3:0]  sresync_p;
	reg [1:0]  tresync_p;
	reg [3:0]  clr;
	reg [3:0]  ind;
	reg [3:0]  ok;
	reg [3:0]  pop;
	reg [3:0]  acc;
	reg        all_ok;
	reg [31:0] rd_data;
	reg        rd_err;

	wire [17:0]     idx;
	wire            setup;
	wire            wr_en;
	wire [3:0]      fin_rdy;
	wire [3:0]      fout_vld;
	wire [3:0]      fafull;
	wire [4*DW-1:0] fout_data;

	integer i;
	integer j;

	assign idx   = paddr[19:2];
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite & ~pslverr & pstrb[0];

	// ----------------------------------------
	// Edge detection and group decode
	// ----------------------------------------
	always @* begin
		for (i = 0; i < 2; i = i + 1) begin
			tresync_p[i] = rlc_q[i][`SRA_BIT_TRESYNC] & ~tresync_prev_q[i];
		end
		for (i = 0; i < 4; i = i + 1) begin
			realign_p[i] = chan_ctrl_q[i/2][`SRA_BIT_REALIGN_C + i%2] & ~realign_prev_q[i];
			sresync_p[i] = rlc_q[i/2][`SRA_BIT_SRESYNC_C + i%2] & ~sresync_prev_q[i];
			clr[i] = sresync_p[i] | tresync_p[i/2];
			ind[i] = byp_act_q[i/2] | ~mem_act_q[i] | ~(twin_act_q[i/2] | quad_act_q[i/2]);
			ok[i]  = fout_vld[i] & (~out_valid[i] | out_ready[i]);
			acc[i] = rx_valid[i] & rx_ready[i] & fin_rdy[i] & ~clr[i]
				& (started_q[i] | rx_comma[i] | ind[i]);
		end
		for (i = 0; i < 4; i = i + 1) begin
			all_ok = 1'b1;
			// members wait for the whole group
			for (j = 0; j < 4; j = j + 1) begin
				if (!ind[j] && ((quad_act_q[i/2] && quad_act_q[j/2])
					|| (i/2 == j/2 && twin_act_q[i/2])))
					all_ok = all_ok & ok[j];
			end
			pop[i] = ind[i] ? ok[i] : (all_ok & ok[i]);
		end
	end

	// ----------------------------------------
	// Alignment buffers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ch
			sra_fifo #(
				.W  (DW),
				.D  (DEPTH),
				.AW (AW)
			) u_fifo (
				.clk       (pclk),
				.rst_n     (presetn),
				.ce        (ce),
				.clr       (clr[g]),
				.in_valid  (acc[g]),
				.in_ready  (fin_rdy[g]),
				.in_data   (rx_data[g*DW +: DW]),
				.out_valid (fout_vld[g]),
				.out_ready (pop[g]),
				.out_data  (fout_data[g*DW +: DW]),
				.afull     (fafull[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			rd_err = 1'b1;
		end else begin
			case (idx)
				`SRA_IDX_CHAN_ALIGN_CTRL_A:  rd_data[7:0] = chan_ctrl_q[0];
				`SRA_IDX_GROUP_MODE_A:       rd_data[7:0] = mode_q[0];
				`SRA_IDX_RESYNC_LINK_CTRL_A: rd_data[7:0] = rlc_q[0];
				`SRA_IDX_ALIGN_BYPASS_A:     rd_data[7:0] = byp_q[0];
				`SRA_IDX_CHAN_ALIGN_CTRL_B:  rd_data[7:0] = chan_ctrl_q[1];
				`SRA_IDX_GROUP_MODE_B:       rd_data[7:0] = mode_q[1];
				`SRA_IDX_RESYNC_LINK_CTRL_B: rd_data[7:0] = rlc_q[1];
				`SRA_IDX_ALIGN_BYPASS_B:     rd_data[7:0] = byp_q[1];
				`SRA_IDX_LINK_SM_SEL:        rd_data[3:0] = lsel_q;
				`SRA_IDX_ALIGN_STATUS:       rd_data[7:0] = {chan_align_done, word_align_done};
				default:                     rd_err = 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// APB slave: one wait-free access phase
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= rd_err;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 2; i = i + 1) begin
				chan_ctrl_q[i] <= `SRA_RST_REG8;
				mode_q[i]      <= `SRA_RST_REG8;
				rlc_q[i]       <= `SRA_RST_REG8;
				byp_q[i]       <= `SRA_RST_REG8;
			end
			lsel_q <= `SRA_RST_SEL4;
		end else if (ce && wr_en) begin
			case (idx)
				`SRA_IDX_CHAN_ALIGN_CTRL_A:  chan_ctrl_q[0] <= pwdata[7:0] & `SRA_MASK_CHAN_CTRL;
				`SRA_IDX_GROUP_MODE_A:       mode_q[0] <= pwdata[7:0];
				`SRA_IDX_RESYNC_LINK_CTRL_A: rlc_q[0] <= pwdata[7:0] & `SRA_MASK_RLC;
				`SRA_IDX_ALIGN_BYPASS_A:     byp_q[0] <= pwdata[7:0] & `SRA_MASK_BYPASS;
				`SRA_IDX_CHAN_ALIGN_CTRL_B:  chan_ctrl_q[1] <= pwdata[7:0] & `SRA_MASK_CHAN_CTRL;
				`SRA_IDX_GROUP_MODE_B:       mode_q[1] <= pwdata[7:0];
				`SRA_IDX_RESYNC_LINK_CTRL_B: rlc_q[1] <= pwdata[7:0] & `SRA_MASK_RLC;
				`SRA_IDX_ALIGN_BYPASS_B:     byp_q[1] <= pwdata[7:0] & `SRA_MASK_BYPASS;
				`SRA_IDX_LINK_SM_SEL:        lsel_q <= pwdata[3:0];
				default:                     lsel_q <= lsel_q;
			endcase
		end
	end

	// ----------------------------------------
	// Applied settings and channel state
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			realign_prev_q      <= 4'h0;
			sresync_prev_q      <= 4'h0;
			tresync_prev_q      <= 2'h0;
			mem_act_q           <= 4'h0;
			twin_act_q          <= 2'h0;
			quad_act_q          <= 2'h0;
			byp_act_q           <= 2'h0;
			hunt_q              <= 4'hf;
			started_q           <= 4'h0;
			word_realign        <= 4'h0;
			word_align_done     <= 4'h0;
			chan_align_done     <= 4'h0;
			xaui_link_sm_select <= 4'h0;
			rx_ready            <= 4'h0;
			out_valid           <= 4'h0;
			out_data            <= {(4*DW){1'b0}};
		end else if (ce) begin
			for (i = 0; i < 2; i = i + 1) begin
				tresync_prev_q[i] <= rlc_q[i][`SRA_BIT_TRESYNC];
				// group settings take effect on resync
				if (tresync_p[i]) begin
					twin_act_q[i] <= (mode_q[i] == `SRA_MODE_TWIN);
					quad_act_q[i] <= (mode_q[i] == `SRA_MODE_QUAD);
				end
				if (tresync_p[i] | sresync_p[2*i] | sresync_p[2*i+1])
					byp_act_q[i] <= byp_q[i][`SRA_BIT_BYPASS];
			end
			for (i = 0; i < 4; i = i + 1) begin
				realign_prev_q[i] <= chan_ctrl_q[i/2][`SRA_BIT_REALIGN_C + i%2];
				sresync_prev_q[i] <= rlc_q[i/2][`SRA_BIT_SRESYNC_C + i%2];
				word_realign[i]   <= realign_p[i];
				if (realign_p[i]) begin
					hunt_q[i]          <= 1'b1;
					word_align_done[i] <= 1'b0;
				end else if (hunt_q[i] && rx_valid[i] && rx_comma[i]) begin
					hunt_q[i]          <= 1'b0;
					word_align_done[i] <= 1'b1;
				end
				if (clr[i]) begin
					mem_act_q[i]       <= chan_ctrl_q[i/2][`SRA_BIT_MEMBER_C + i%2];
					started_q[i]       <= 1'b0;
					chan_align_done[i] <= 1'b0;
				end else begin
					if (acc[i])
						started_q[i] <= 1'b1;
					if (pop[i] && !ind[i])
						chan_align_done[i] <= 1'b1;
				end
				xaui_link_sm_select[i] <= rlc_q[i/2][`SRA_BIT_XAUI] | lsel_q[i];
				// One-slot margin so a write in flight always fits
				rx_ready[i] <= ~fafull[i];
				if (pop[i]) begin
					out_valid[i]             <= 1'b1;
					out_data[i*DW +: DW]     <= fout_data[i*DW +: DW];
				end else if (out_ready[i]) begin
					out_valid[i] <= 1'b0;
				end
			end
		end
	end
endmodule // sra_align_ctrl

`default_nettype wire

//--- verification/sra_align_ctrl_checker.sv
// Concurrent checks on the ports of the alignment control top.
// Assumes APB masters that follow the setup/access order, idle while ce is low.
`timescale 1ns/10ps
`default_nettype none
`include "sra_defs.vh"
module sra_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  word_realign,
	input wire logic [3:0]  word_align_done
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_APB_ANSWER:
		assert property (ce && psel && !penable |=> pready) else $error("no answer");
	AST_APB_ONE:
		assert property (ce && pready |=> !pready) else $error("pready held");
	AST_ERR_READY:
		assert property (pslverr |-> pready) else $error("stray pslverr");
	AST_ERR_ZERO:
		assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
	AST_RSVD_ZERO:
		assert property (pready && !pwrite && !pslverr
			&& paddr[19:2] == `SRA_IDX_CHAN_ALIGN_CTRL_A |-> (prdata & ~32'hcc) == 32'h0)
			else $error("reserved bits set");
	AST_REALIGN_ONE:
		assert property (word_realign != 4'h0 |=> (word_realign & $past(word_realign)) == 4'h0)
			else $error("realign pulse too long");
	AST_REALIGN_CAUSE:
		assert property (word_realign != 4'h0 |-> $past(pready && pwrite, 2))
			else $error("realign without write");
	AST_DONE_CLEAR:
		assert property (word_realign[0] |-> ##[0:1] !word_align_done[0])
			else $error("align done not cleared");
endmodule // sra_checker

bind sra_align_ctrl sra_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .word_realign(word_realign), .word_align_done(word_align_done));
`default_nettype wire

//--- verification/sra_rx_partner.sv
// Far-side model: four receive channels and the fabric sink.
// Assumes the bench feeds random bits and a stall request on pclk.
`timescale 1ns/10ps
`default_nettype none
module sra_rx_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        stall,
	input  wire logic [7:0]  rnd,
	input  wire logic [3:0]  rx_ready,
	output logic      [3:0]  rx_valid,
	output logic      [35:0] rx_data,
	output logic      [3:0]  rx_comma,
	output logic      [3:0]  out_ready
);
	logic [8:0] cnt_q [4];
	assign out_ready = stall ? 4'h0 : (rnd[3:0] | rnd[7:4]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_valid <= 4'h0;
			for (int i = 0; i < 4; i++) cnt_q[i] <= 9'h000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (rx_valid[i] && rx_ready[i]) cnt_q[i] <= cnt_q[i] + 9'h001;
				// Offered word stays put until taken
				if (!rx_valid[i] || rx_ready[i]) rx_valid[i] <= rnd[i] | rnd[i+4];
			end
		end
	end
	// Idle lines show the inverse so stale data cannot pass
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			rx_data[9*i +: 9] = rx_valid[i] ? cnt_q[i] : ~cnt_q[i];
			rx_comma[i] = rx_valid[i] && cnt_q[i][1:0] == 2'b00;
		end
	end
endmodule // sra_rx_partner
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the alignment control top.
// Assumes the checker is bound and the partner drives the stream side.
`timescale 1ns/10ps
`default_nettype none
`include "sra_defs.vh"
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic stall = 1'b0;
	logic [19:0] paddr = 20'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0] pstrb = 4'h0;
	logic [7:0] rnd = 8'h0, d;
	logic er;
	logic ce = 1'b1, seq_on = 1'b0, have_q = 1'b0;
	logic [8:0] last_q = 9'h000;
	logic [23:0] snap;
	wire logic [31:0] prdata;
	wire logic pready, pslverr;
	wire logic [3:0] rxv, rxc, rxr, ov, ordy, wr_al, xs, wad, cad;
	wire logic [35:0] rxd, od;
	wire logic [23:0] mon = {ov, cad, wad, xs, rxr, wr_al};
	int seed = 39350, errors = 0, total_checks = 0, k;
	logic [17:0] idx [8] = '{`SRA_IDX_CHAN_ALIGN_CTRL_A, `SRA_IDX_GROUP_MODE_A,
		`SRA_IDX_RESYNC_LINK_CTRL_A, `SRA_IDX_ALIGN_BYPASS_A, `SRA_IDX_CHAN_ALIGN_CTRL_B,
		`SRA_IDX_GROUP_MODE_B, `SRA_IDX_RESYNC_LINK_CTRL_B, `SRA_IDX_ALIGN_BYPASS_B};
	logic [7:0] msk [8] = '{8'hcc, 8'hff, 8'hac, 8'h01, 8'hcc, 8'hff, 8'hac, 8'h01};
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) rnd <= 8'($random(seed));
	sra_align_ctrl DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rxv), .rx_data(rxd),
		.rx_comma(rxc), .rx_ready(rxr), .out_valid(ov), .out_data(od), .out_ready(ordy),
		.word_realign(wr_al), .xaui_link_sm_select(xs), .word_align_done(wad),
		.chan_align_done(cad));
	sra_rx_partner u_far (.pclk(pclk), .presetn(presetn), .stall(stall), .rnd(rnd),
		.rx_ready(rxr), .rx_valid(rxv), .rx_data(rxd), .rx_comma(rxc), .out_ready(ordy));
	task final_report;
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// One idle cycle between transfers keeps each signal to one write per step
	task apb(input logic w, input logic [17:0] i, input logic [7:0] v, input logic [3:0] s);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, i, 2'b00, 24'h0, v, s};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
		if (n >= 50) errors++;
	endtask
	task wr(input logic [17:0] i, input logic [7:0] v);
		apb(1'b1, i, v, 4'h1);
	endtask
	task wait_for(input int b, input logic v);
		int n;
		n = 0;
		do begin @(negedge pclk); n++; end while (mon[b] !== v && n < 400);
		chk({31'h0, mon[b]}, {31'h0, v});
	endtask
	always @(negedge pclk) begin
		if (seq_on && ce && ov[0] && ordy[0]) begin
			if (have_q) chk({23'h0, od[8:0]}, {23'h0, last_q + 9'h001});
			last_q <= od[8:0];
			have_q <= 1'b1;
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		final_report;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 8; k++) begin
			apb(1'b0, idx[k], 8'h00, 4'h1);
			chk(rd, 32'h0);
		end
		for (k = 0; k < 8; k++) begin
			d = rnd & 8'hcf;
			wr(idx[k], d);
			apb(1'b0, idx[k], 8'h00, 4'h1);
			chk(rd, {24'h0, d & msk[k]});
		end
		for (k = 0; k < 8; k++) wr(idx[k], 8'h00);
		apb(1'b0, 18'h30812, 8'h00, 4'h1);
		chk({31'h0, er}, 32'h1);
		wr(`SRA_IDX_GROUP_MODE_A, 8'h5a);
		apb(1'b1, `SRA_IDX_GROUP_MODE_A, 8'h33, 4'h0);
		apb(1'b0, `SRA_IDX_GROUP_MODE_A, 8'h00, 4'h1);
		chk(rd, 32'h5a);
		wr(`SRA_IDX_CHAN_ALIGN_CTRL_A, 8'h04);
		wait_for(0, 1'b1);
		wait_for(12, 1'b1);
		wr(`SRA_IDX_LINK_SM_SEL, 8'h05);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_A, 8'h80);
		wait_for(9, 1'b1);
		wait_for(11, 1'b0);
		wait_for(10, 1'b1);
		wr(`SRA_IDX_CHAN_ALIGN_CTRL_A, 8'hc0);
		wr(`SRA_IDX_GROUP_MODE_A, `SRA_MODE_TWIN);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_A, 8'h20);
		wait_for(16, 1'b1);
		wait_for(17, 1'b1);
		wr(`SRA_IDX_CHAN_ALIGN_CTRL_B, 8'hc0);
		wr(`SRA_IDX_GROUP_MODE_B, `SRA_MODE_NONE);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_B, 8'h20);
		repeat (60) @(posedge pclk);
		chk({30'h0, cad[3:2]}, 32'h0);
		wr(`SRA_IDX_CHAN_ALIGN_CTRL_B, 8'h00);
		for (k = 0; k < 2; k++) begin
			wr(k ? `SRA_IDX_GROUP_MODE_B : `SRA_IDX_GROUP_MODE_A, `SRA_MODE_QUAD);
			wr(k ? `SRA_IDX_RESYNC_LINK_CTRL_B : `SRA_IDX_RESYNC_LINK_CTRL_A, 8'h00);
			wr(k ? `SRA_IDX_RESYNC_LINK_CTRL_B : `SRA_IDX_RESYNC_LINK_CTRL_A, 8'h20);
		end
		repeat (60) @(posedge pclk);
		chk({30'h0, cad[3:2]}, 32'h0);
		wr(`SRA_IDX_CHAN_ALIGN_CTRL_B, 8'hc0);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_B, 8'h00);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_B, 8'h20);
		for (k = 16; k < 20; k++) wait_for(k, 1'b1);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_A, 8'h24);
		wait_for(16, 1'b0);
		wr(`SRA_IDX_ALIGN_BYPASS_A, 8'h01);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_A, 8'h00);
		wr(`SRA_IDX_RESYNC_LINK_CTRL_A, 8'h20);
		wait_for(20, 1'b1);
		repeat (20) @(posedge pclk);
		chk({30'h0, cad[1:0]}, 32'h0);
		seq_on <= 1'b1;
		@(posedge pclk);
		stall <= 1'b1;
		wait_for(4, 1'b0);
		@(posedge pclk);
		stall <= 1'b0;
		wait_for(4, 1'b1);
		// Partner keeps counting while frozen, so order check stops on the same edge as ce
		@(posedge pclk);
		seq_on <= 1'b0;
		ce <= 1'b0;
		@(negedge pclk);
		snap = mon;
		repeat (8) @(negedge pclk);
		chk({8'h0, mon}, {8'h0, snap});
		@(posedge pclk);
		ce <= 1'b1;
		final_report;
	end
endmodule // tb
`default_nettype wire
